// ===== rtl/ain_scan_ctrl.sv
// Analog input scan controller: backplane slave, broken-wire test and sampling sequencer
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ain_scan_ctrl #(
    parameter logic [15:0] TEST_CYCLES = 16'(ain_scan_pkg::TEST_PULSE_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Backplane register port
    input wire ain_scan_pkg::bus_req_type bus_req,
    output ain_scan_pkg::bus_rsp_type bus_rsp,
    // Enable circuit
    input wire logic enable_in,
    input wire logic enable_jumper_in,
    // Address and mode selectors
    input wire ain_scan_pkg::switch_type switches,
    // Broken-wire test current and limit comparator
    input wire logic test_inhibit,
    input wire logic wire_open,
    output logic test_current_on,
    // Converter
    input wire ain_scan_pkg::conv_rsp_type conv_rsp,
    output logic conv_start,
    output logic [2:0] conv_chan
);

    ain_scan_pkg::state_type state_r;
    ain_scan_pkg::state_type state_nxt;

    // Channel covered by broken-wire detection under the current switches
    function automatic logic bw_selected(input logic [2:0] ch, input logic [7:0] mode_a);
        logic in_range;
        in_range = mode_a[ain_scan_pkg::MODE_A_BW_ALL_BIT] ||
                   (ch < 3'(ain_scan_pkg::BW_HALF_CHANNELS));
        return mode_a[ain_scan_pkg::MODE_A_BW_ENABLE_BIT] && in_range;
    endfunction

    // Pack converter output into high/low byte layout
    function automatic logic [15:0] pack_result(input logic [11:0] value,
                                                input logic overflow,
                                                input logic broken);
        logic [15:0] word;
        word = 16'h0000;
        if (!broken) begin
            word[15:4] = value;
        end
        word[ain_scan_pkg::LO_OVERFLOW_BIT] = overflow && !broken;
        word[ain_scan_pkg::LO_BROKEN_BIT] = broken;
        return word;
    endfunction

    logic responding;
    logic [7:0] base_addr;
    logic [7:0] offset;
    logic hit;
    logic selective;
    logic [2:0] last_chan;
    logic [2:0] hit_chan;

    always_comb begin
        // Open jumper takes the enable voltage out of the decision
        responding = !enable_jumper_in || enable_in;
        base_addr = {switches.addr_sel, 2'b00};
        offset = 8'(bus_req.addr - base_addr);
        hit = responding && (offset < ain_scan_pkg::WINDOW_BYTES);
        hit_chan = offset[3:1];
        selective = switches.mode_a[ain_scan_pkg::MODE_A_SELECTIVE_BIT];
        last_chan = switches.mode_b[ain_scan_pkg::MODE_B_LAST_LSB +: 3];
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.rsp.ack = 1'b0;
        state_nxt.rsp.rdata = 8'h00;
        state_nxt.conv_start = 1'b0;

        // Bus slave; a disabled module stays silent so the controller times out
        if (bus_req.rd && hit) begin
            state_nxt.rsp.ack = 1'b1;
            if (!offset[0]) begin
                state_nxt.rsp.rdata = state_r.result[hit_chan][15:8];
            end else begin
                state_nxt.rsp.rdata = state_r.result[hit_chan][7:0];
                // A queued start already reads busy, so a read right after the write is safe
                state_nxt.rsp.rdata[ain_scan_pkg::LO_BUSY_BIT] = state_r.busy[hit_chan] ||
                    (state_r.sel_pend && state_r.sel_chan == hit_chan);
            end
        end
        unique case (state_r.phase)
            ain_scan_pkg::ST_IDLE: begin
                if (selective && state_r.sel_pend) begin
                    state_nxt.chan = state_r.sel_chan;
                    state_nxt.sel_pend = 1'b0;
                    state_nxt.busy[state_r.sel_chan] = 1'b1;
                    state_nxt.phase = ain_scan_pkg::ST_TEST;
                end else if (!selective) begin
                    state_nxt.phase = ain_scan_pkg::ST_TEST;
                end
                state_nxt.cnt = '0;
                state_nxt.open_seen = 1'b0;
                state_nxt.tested = 1'b0;
            end
            ain_scan_pkg::ST_TEST: begin
                if (bw_selected(state_r.chan, switches.mode_a) && !test_inhibit) begin
                    state_nxt.test_on = 1'b1;
                    state_nxt.tested = 1'b1;
                    state_nxt.cnt = 16'(state_r.cnt + 16'h0001);
                    if (state_r.cnt == TEST_CYCLES) begin
                        // Compare against the limit at the end of the pulse
                        state_nxt.open_seen = wire_open;
                        state_nxt.test_on = 1'b0;
                        state_nxt.conv_start = 1'b1;
                        state_nxt.phase = ain_scan_pkg::ST_CONV;
                    end
                end else begin
                    // Inhibited or deselected: no current, flag stays clear
                    state_nxt.test_on = 1'b0;
                    state_nxt.open_seen = 1'b0;
                    state_nxt.conv_start = 1'b1;
                    state_nxt.phase = ain_scan_pkg::ST_CONV;
                end
            end
            ain_scan_pkg::ST_CONV: begin
                if (conv_rsp.done) begin
                    state_nxt.result[state_r.chan] =
                        pack_result(conv_rsp.value, conv_rsp.overflow,
                                    state_r.open_seen && state_r.tested);
                    state_nxt.busy[state_r.chan] = 1'b0;
                    state_nxt.phase = ain_scan_pkg::ST_IDLE;
                    if (!selective) begin
                        state_nxt.chan = (state_r.chan >= last_chan) ? 3'h0 :
                                         3'(state_r.chan + 3'h1);
                    end
                end
            end
        endcase

        // After the sequencer, so a start landing on a pickup cycle is not lost
        if (bus_req.wr && hit) begin
            state_nxt.rsp.ack = 1'b1;
            // A start while one is still queued replaces it; only one request is held
            if (selective) begin
                state_nxt.sel_pend = 1'b1;
                state_nxt.sel_chan = hit_chan;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '{phase: ain_scan_pkg::ST_IDLE, default: '0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign bus_rsp = state_r.rsp;
    assign test_current_on = state_r.test_on;
    assign conv_start = state_r.conv_start;
    assign conv_chan = state_r.chan;

endmodule

`default_nettype wire

// ===== rtl/ain_scan_pkg.sv
// Constants, types and field layout for the analog input scan controller
package ain_scan_pkg;

    localparam int CHANNELS = 8;
    localparam int BW_HALF_CHANNELS = 4;
    localparam int VALUE_W = 12;
    localparam int CNT_W = 16;

    // Timing of the broken-wire test pulse
    localparam int CLK_PERIOD_NS = 100;
    localparam int TEST_PULSE_NS = 1600000;
    localparam int TEST_PULSE_CYCLES = (TEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Each channel occupies two bytes; the module window spans all channels
    localparam logic [7:0] WINDOW_BYTES = 8'h10;

    // Low-byte flag positions
    localparam int LO_OVERFLOW_BIT = 0;
    localparam int LO_BROKEN_BIT = 1;
    localparam int LO_BUSY_BIT = 2;

    // Mode switch bank A fields
    localparam int MODE_A_SELECTIVE_BIT = 0;
    localparam int MODE_A_BW_ENABLE_BIT = 1;
    localparam int MODE_A_BW_ALL_BIT = 2;
    // Mode switch bank B fields
    localparam int MODE_B_LAST_LSB = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TEST = 3'b010,
        ST_CONV = 3'b100
    } phase_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef struct packed {
        logic [7:0] rdata;
        logic ack;
    } bus_rsp_type;

    typedef struct packed {
        logic [7:0] mode_a;
        logic [7:0] mode_b;
        logic [5:0] addr_sel;
    } switch_type;

    typedef struct packed {
        logic done;
        logic [VALUE_W-1:0] value;
        logic overflow;
    } conv_rsp_type;

    typedef struct packed {
        phase_type phase;
        logic [2:0] chan;
        logic [CNT_W-1:0] cnt;
        logic open_seen;
        logic tested;
        logic sel_pend;
        logic [2:0] sel_chan;
        logic [CHANNELS-1:0] busy;
        logic [CHANNELS-1:0][15:0] result;
        bus_rsp_type rsp;
        logic conv_start;
        logic test_on;
    } state_type;

endpackage

// ===== bench/ain_scan_ctrl_sva.sv
// Port assertions for the scan controller
`timescale 1ns/1ps
`default_nettype none
module ain_scan_sva #(
    parameter logic [15:0] TEST_CYCLES = 16'h0008
) (
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rst,
    input wire ain_scan_pkg::bus_req_type bus_req,
    input wire ain_scan_pkg::bus_rsp_type bus_rsp,
    // Enable, switches, test current and conversion start
    input wire logic enable_in,
    input wire logic enable_jumper_in,
    input wire ain_scan_pkg::switch_type switches,
    input wire logic test_inhibit,
    input wire logic test_current_on,
    input wire logic conv_start
);
    logic [15:0] on_cnt_r;
    logic [7:0] offs;
    logic hit;
    logic stb;
    assign offs = bus_req.addr - {switches.addr_sel, 2'b00};
    assign hit = offs < ain_scan_pkg::WINDOW_BYTES;
    assign stb = bus_req.rd | bus_req.wr;
    // Counts how long the test current has been on
    always_ff @(posedge clk) begin
        on_cnt_r <= (rst || !test_current_on) ? 16'h0000 : on_cnt_r + 16'h0001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence test_done; $fell(test_current_on); endsequence
    a_gated_off: assert property (stb && enable_jumper_in && !enable_in |=> !bus_rsp.ack)
        else $error("ack while disabled");
    a_jumper_open: assert property (stb && hit && !enable_jumper_in |=> bus_rsp.ack)
        else $error("no ack with jumper open");
    a_addr_miss: assert property (stb && !hit |=> !bus_rsp.ack)
        else $error("ack outside window");
    a_ack_cause: assert property (bus_rsp.ack |-> $past(stb && hit))
        else $error("ack without access");
    a_hit_ack: assert property (stb && hit && enable_in |=> bus_rsp.ack)
        else $error("missing ack");
    a_inhibit_off: assert property (test_inhibit [*2] |-> !test_current_on)
        else $error("test current while inhibited");
    a_test_start: assert property (test_done |-> ##[0:2] conv_start)
        else $error("no conversion after test");
    a_pulse_len: assert property (test_done |-> on_cnt_r == TEST_CYCLES)
        else $error("test pulse length wrong");
endmodule
bind ain_scan_ctrl ain_scan_sva #(.TEST_CYCLES(TEST_CYCLES)) chk (.clk(clk), .rst(rst),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .enable_in(enable_in),
    .enable_jumper_in(enable_jumper_in), .switches(switches), .test_inhibit(test_inhibit),
    .test_current_on(test_current_on), .conv_start(conv_start));
`default_nettype wire

// ===== bench/conv_model.sv
// Converter and sensor comparator model
`timescale 1ns/1ps
`default_nettype none
module conv_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // From the controller
    input wire logic conv_start,
    input wire logic [2:0] conv_chan,
    input wire logic test_current_on,
    // To the controller
    output ain_scan_pkg::conv_rsp_type conv_rsp,
    output logic wire_open
);
    int wait_r;
    logic [11:0] val;
    assign val = {1'b0, conv_chan, 8'hA5};
    // Channel 6 stands for an open sensor line
    assign wire_open = test_current_on && conv_chan == 3'h6;
    assign conv_rsp.done = wait_r == 1;
    // Outside done the result lines carry junk so a stale value cannot pass
    assign conv_rsp.value = conv_rsp.done ? val : ~val;
    assign conv_rsp.overflow = conv_rsp.done ? conv_chan == 3'h5 : conv_chan != 3'h5;
    // Odd channels answer slowly
    always @(posedge clk) begin
        if (rst) begin
            wait_r <= 0;
        end else if (conv_start) begin
            wait_r <= conv_chan[0] ? 6 : 2;
        end else if (wait_r > 0) begin
            wait_r <= wait_r - 1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/analog_input_scan_and_enable_tb_top.sv
// Self-checking bench for the scan controller
`timescale 1ns/1ps
`default_nettype none
module analog_input_scan_and_enable_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ain_scan_pkg::bus_req_type req = '0;
    ain_scan_pkg::bus_rsp_type rsp;
    ain_scan_pkg::switch_type sw = '0;
    ain_scan_pkg::conv_rsp_type crsp;
    logic en = 1'b1;
    logic jmp = 1'b1;
    logic inh = 1'b0;
    logic wopen, tcur, cstart, ok;
    logic [2:0] cchan;
    logic [7:0] rnd = 8'h19;
    logic [7:0] d;
    int miscompares = 0;
    int checks_done = 0;
    ain_scan_ctrl #(.TEST_CYCLES(16'h0008)) DUT (.clk(clk), .rst(rst), .bus_req(req),
        .bus_rsp(rsp), .enable_in(en), .enable_jumper_in(jmp), .switches(sw),
        .test_inhibit(inh), .wire_open(wopen), .test_current_on(tcur), .conv_rsp(crsp),
        .conv_start(cstart), .conv_chan(cchan));
    conv_model CONV (.clk(clk), .rst(rst), .conv_start(cstart), .conv_chan(cchan),
        .test_current_on(tcur), .conv_rsp(crsp), .wire_open(wopen));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus cycle; ok is low when no acknowledge came, which the CPU takes as a timeout
    task automatic access(input logic wr, input logic [7:0] a);
        @(posedge clk);
        req <= '{a, rnd, wr, !wr};
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1;
        ok = rsp.ack;
        d = rsp.rdata;
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [15:0] expv(input int c, input logic [7:0] ma, input int last,
                                         input logic ih);
        if (c > last) return 16'h0000;
        if (ma[1] && ma[2] && !ih && c == 6) return 16'h0002;
        return {1'b0, 3'(c), 8'hA5, 3'b000, c == 5};
    endfunction
    task automatic run(input logic [7:0] ma, input logic [2:0] last, input logic ih,
                       input string name);
        logic [7:0] b;
        logic [15:0] e;
        rnd = lfsr(rnd);
        b = {rnd[5] | ma[0], rnd[4:0], 2'b00};
        sw <= '{ma, {5'h00, last}, b[7:2]};
        inh <= ih;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        if (!ma[0]) repeat (400) @(posedge clk);
        for (int c = 0; c < 8; c++) begin
            e = expv(c, ma, last, ih);
            if (ma[0]) access(1'b1, b + 8'(2 * c));
            for (int k = 0; k < 60 && ma[0]; k++) begin
                access(1'b0, b + 8'(2 * c + 1));
                if (k == 0) chk({8'h00, d[2]}, 9'h001);
                if (d[2] === 1'b0) break;
            end
            access(1'b0, b + 8'(2 * c));
            chk({ok, d}, {1'b1, e[15:8]});
            access(1'b0, b + 8'(2 * c + 1));
            chk({ok, d}, {1'b1, e[7:0]});
        end
        en <= 1'b0;
        access(1'b0, b);
        chk({ok, d}, 9'h000);
        jmp <= 1'b0;
        access(1'b0, b);
        e = expv(0, ma, last, ih);
        chk({ok, d}, {1'b1, e[15:8]});
        en <= 1'b1;
        jmp <= 1'b1;
        access(1'b0, b + 8'h10);
        chk({ok, d}, 9'h000);
        $display("Test %s done", name);
    endtask
    initial begin
        run(8'h00, 3'h7, 1'b0, "plain cyclic");
        run(8'h02, 3'h7, 1'b0, "first four");
        run(8'h06, 3'h7, 1'b0, "all eight");
        run(8'h06, 3'h7, 1'b1, "inhibited");
        run(8'h00, 3'h2, 1'b0, "short scan");
        run(8'h07, 3'h7, 1'b0, "selective");
        end_sim;
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
